// *** hw/buck_ldo_pkg.sv ***
// Functional notes
// - Bucks 1-2 soft-start through eight stages
// - Bucks 3-4 use two intermediate stages
// - Hysteretic bucks 3-4 capped by field
// - Capacitance setting loads only from configuration
// - Disabled buck floats or discharges per bit
// - Bucks 1-2 switch 2/4 MHz, configuration-only
// - Buck 3 always switches at 2 MHz
// - Switching phase follows phase select bits
// - Source 01 or pin selects alternate voltage
// - Alternate voltage overrides on, sleep, hardware
// - Bucks 1-2 voltage changes slew at ramp rate; bucks 3-4 jump
// - Done pin low during voltage transition
// - Done tracks all slews, not accuracy
// - Ganged buck 4 follows buck 3 controls
// - Ganged auto mode runs forced continuous instead
// - Ganged hysteretic/linear limit equals buck 3
// - Switch mode closes switch when enabled
// - Disabled regulator outside switch mode floats or discharges per bit
// - On/sleep voltage fields pick default target
// - Hardware control input replaces mode, voltage while buck enabled
package buck_ldo_pkg;

  localparam int unsigned N_BUCK = 4;
  localparam int unsigned N_REG = 10;
  localparam int unsigned VSEL_W = 7;

  typedef enum logic [1:0] {
    MODE_AUTO = 2'b00,
    MODE_FORCED_CONTINUOUS_MODE = 2'b01,
    MODE_HYST = 2'b10,
    MODE_LDO  = 2'b11
  } buck_mode_e;

  localparam logic [1:0] SCALING_SRC_SOFT = 2'h1;

  // Switching period counter, 5 ns clock
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SW_PERIOD_2M_NS = 500;
  localparam int unsigned SW_PERIOD_4M_NS = 250;
  localparam logic [6:0] SW_CYC_2M = 7'(SW_PERIOD_2M_NS / CLK_PERIOD_NS);
  localparam logic [6:0] SW_CYC_4M = 7'(SW_PERIOD_4M_NS / CLK_PERIOD_NS);
  localparam logic [6:0] PHASE_STEP_2M = 7'(SW_CYC_2M / 4);
  localparam logic [6:0] PHASE_STEP_4M = 7'(SW_CYC_4M / 4);

  // Soft-start stage unit; real count is a top parameter
  localparam int unsigned SS_UNIT_US = 32;
  localparam int unsigned SS_UNIT_CYC_DEF = SS_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [2:0] SS_FULL = 3'h7;
  localparam logic [2:0] SS_LAST_34 = 3'h2;

  // Voltage ramp: one code step per base time shifted by rate
  localparam int unsigned RAMP_STEP_NS = 1000;
  localparam logic [10:0] RAMP_BASE_CYC = 11'(RAMP_STEP_NS / CLK_PERIOD_NS);

  localparam logic [1:0] FREQ_RESET = 2'h0;
  localparam logic GANG_RESET = 1'b0;
  localparam logic [N_BUCK*2-1:0] CAP_RESET = 8'h00;

  function automatic logic [15:0] ss_cycles(input logic [15:0] unit, input logic [1:0] sel);
    ss_cycles = unit << sel;
  endfunction : ss_cycles

  function automatic logic [10:0] ramp_cycles(input logic [1:0] sel);
    ramp_cycles = RAMP_BASE_CYC << sel;
  endfunction : ramp_cycles

  function automatic logic phase_tick(input logic [6:0] cnt, input logic fast,
                                      input logic [1:0] ph);
    logic [6:0] c;
    c = (cnt >= SW_CYC_4M) ? 7'(cnt - SW_CYC_4M) : cnt;
    if (fast) begin
      phase_tick = (c == 7'(PHASE_STEP_4M * ph));
    end else begin
      phase_tick = (cnt == 7'(PHASE_STEP_2M * ph));
    end
  endfunction : phase_tick

endpackage : buck_ldo_pkg

// *** hw/buck_slew.sv ***
`timescale 1ns/1ps
`default_nettype none
module buck_slew (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [buck_ldo_pkg::VSEL_W-1:0] target_i,
  input wire logic [1:0] rate_i,
  output logic [buck_ldo_pkg::VSEL_W-1:0] voltage_o,
  output logic done_o
);
  import buck_ldo_pkg::*;

  typedef struct packed {
    logic init;
    logic [VSEL_W-1:0] cur;
    logic [VSEL_W-1:0] last_tgt;
    logic [10:0] timer;
    logic done;
  } slew_s;

  slew_s q, d;

  always_comb begin
    d = q;
    d.last_tgt = target_i;
    if (!q.init) begin
      // First target after reset is taken without a ramp
      d.init = 1'b1;
      d.cur = target_i;
      d.timer = 11'h000;
    end else if (q.cur != target_i) begin
      if (target_i != q.last_tgt) begin
        d.timer = 11'h000;
      end else if (q.timer >= 11'(ramp_cycles(rate_i) - 11'h001)) begin
        d.timer = 11'h000;
        d.cur = (q.cur < target_i) ? VSEL_W'(q.cur + 1'b1) : VSEL_W'(q.cur - 1'b1);
      end else begin
        d.timer = 11'(q.timer + 11'h001);
      end
    end else begin
      d.timer = 11'h000;
    end
    d.done = (d.cur == target_i);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{init: 1'b0, cur: '0, last_tgt: '0, timer: 11'h000, done: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign voltage_o = q.cur;
  assign done_o = q.done;

  a_slew_one_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(q.init) && $changed(q.cur) |-> (q.cur == VSEL_W'($past(q.cur) + 1'b1))
      || (q.cur == VSEL_W'($past(q.cur) - 1'b1)))
    else $error("Slew moved more than one code");

endmodule : buck_slew
`default_nettype wire

// *** hw/buck_ldo_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module buck_ldo_ctrl #(
  parameter int unsigned SS_UNIT_CYC = buck_ldo_pkg::SS_UNIT_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic nv_load_i,
  input wire logic [1:0] nv_switch_freq_sel_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][1:0] nv_output_capacitance_sel_i,
  input wire logic nv_gang_enable_i,
  input wire logic sleep_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0] buck_enable_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][1:0] buck_softstart_step_time_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0] buck_off_discharge_sel_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][1:0] buck_switch_phase_sel_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][buck_ldo_pkg::VSEL_W-1:0] buck_on_state_voltage_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][buck_ldo_pkg::VSEL_W-1:0] buck_sleep_voltage_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][1:0] buck_on_mode_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][1:0] buck_sleep_mode_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0] hardware_control_input_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][buck_ldo_pkg::VSEL_W-1:0] buck_hwc_voltage_i,
  input wire logic [buck_ldo_pkg::N_BUCK-1:0][1:0] buck_hwc_mode_i,
  input wire logic [1:0][buck_ldo_pkg::VSEL_W-1:0] buck_alternate_voltage_i,
  input wire logic [1:0][1:0] buck_scaling_source_i,
  input wire logic [1:0] voltage_scaling_pin_i,
  input wire logic [1:0][1:0] buck_ramp_rate_i,
  input wire logic [1:0] buck3_hysteretic_current_cap_i,
  input wire logic [1:0] buck4_hysteretic_current_cap_i,
  input wire logic [buck_ldo_pkg::N_REG-1:0] regulator_enable_i,
  input wire logic [buck_ldo_pkg::N_REG-1:0] regulator_switch_mode_i,
  input wire logic [buck_ldo_pkg::N_REG-1:0] regulator_off_discharge_sel_i,
  output logic [buck_ldo_pkg::N_BUCK-1:0][1:0] buck_output_capacitance_sel_o,
  output logic [1:0] buck_switch_freq_sel_o,
  output logic buck_gang_enable_o,
  output logic [buck_ldo_pkg::N_BUCK-1:0] buck_switch_tick_o,
  output logic [buck_ldo_pkg::N_BUCK-1:0] buck_power_on_o,
  output logic [buck_ldo_pkg::N_BUCK-1:0][2:0] buck_ilim_stage_o,
  output logic [buck_ldo_pkg::N_BUCK-1:0][buck_ldo_pkg::VSEL_W-1:0] buck_target_voltage_o,
  output logic [buck_ldo_pkg::N_BUCK-1:0][1:0] buck_mode_o,
  output logic [1:0][1:0] buck_hyst_cap_o,
  output logic [1:0] buck_hyst_cap_active_o,
  output logic buck_gang_single_limit_o,
  output logic [buck_ldo_pkg::N_BUCK-1:0] buck_discharge_o,
  output logic buck1_scaling_done_pin_o,
  output logic buck2_scaling_done_pin_o,
  output logic [buck_ldo_pkg::N_REG-1:0] regulator_switch_closed_o,
  output logic [buck_ldo_pkg::N_REG-1:0] regulator_regulate_o,
  output logic [buck_ldo_pkg::N_REG-1:0] regulator_discharge_o
);
  import buck_ldo_pkg::*;

  typedef struct packed {
    logic [6:0] sw_cnt;
    logic [1:0] freq;
    logic [N_BUCK-1:0][1:0] cap;
    logic gang;
    logic [N_BUCK-1:0] pwr;
    logic [N_BUCK-1:0][2:0] ss_stage;
    logic [N_BUCK-1:0][15:0] ss_timer;
    logic [N_BUCK-1:0] tick;
    logic [N_BUCK-1:0][VSEL_W-1:0] tgt;
    logic [N_BUCK-1:0][1:0] mode;
    logic [1:0][1:0] hyst_cap;
    logic [1:0] hyst_act;
    logic gang_single;
    logic [N_BUCK-1:0] discharge;
    logic [1:0] done;
    logic [N_REG-1:0] reg_closed;
    logic [N_REG-1:0] reg_reg;
    logic [N_REG-1:0] reg_dis;
  } ctrl_s;

  ctrl_s q, d;
  logic [1:0][VSEL_W-1:0] slew_tgt;
  logic [1:0][VSEL_W-1:0] slew_v;
  logic [1:0] slew_done;

  // ----------------------------------------------------------------
  // Voltage ramps for bucks 1 and 2
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_slew
    buck_slew u_slew (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .target_i(slew_tgt[g]),
      .rate_i(buck_ramp_rate_i[g]),
      .voltage_o(slew_v[g]),
      .done_o(slew_done[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    int s;
    logic en;
    logic [VSEL_W-1:0] v;
    buck_mode_e m;
    logic fast;
    s = 0;
    en = 1'b0;
    v = '0;
    m = MODE_AUTO;
    fast = 1'b0;
    d = q;
    slew_tgt = '0;
    if (nv_load_i) begin
      // Configuration-only fields; nothing else writes them
      d.freq = nv_switch_freq_sel_i;
      d.cap = nv_output_capacitance_sel_i;
      d.gang = nv_gang_enable_i;
    end
    d.sw_cnt = (q.sw_cnt >= 7'(SW_CYC_2M - 7'h01)) ? 7'h00 : 7'(q.sw_cnt + 7'h01);
    for (int i = 0; i < int'(N_BUCK); i++) begin
      s = (i == 3 && q.gang) ? 2 : i;
      en = buck_enable_i[s];
      // Operating point: on/sleep, then hardware control, then scaling
      v = sleep_i ? buck_sleep_voltage_i[s] : buck_on_state_voltage_i[s];
      m = buck_mode_e'(sleep_i ? buck_sleep_mode_i[s] : buck_on_mode_i[s]);
      if (hardware_control_input_i[s] && en) begin
        v = buck_hwc_voltage_i[s];
        m = buck_mode_e'(buck_hwc_mode_i[s]);
      end
      if (i < 2 && (buck_scaling_source_i[i[0]] == SCALING_SRC_SOFT
          || voltage_scaling_pin_i[i[0]])) begin
        v = buck_alternate_voltage_i[i[0]];
      end
      if (i >= 2 && q.gang && m == MODE_AUTO) begin
        m = MODE_FORCED_CONTINUOUS_MODE;
      end
      d.mode[i] = m;
      if (i < 2) begin
        slew_tgt[i[0]] = v;
        d.tgt[i] = slew_v[i[0]];
      end else begin
        d.tgt[i] = v;
      end
      d.pwr[i] = en;
      d.discharge[i] = !en && !buck_off_discharge_sel_i[s];
      // Soft-start: restart from stage 0 on every enable
      if (!en || !q.pwr[i]) begin
        d.ss_stage[i] = 3'h0;
        d.ss_timer[i] = 16'h0000;
      end else if (q.ss_stage[i] != SS_FULL) begin
        if (q.ss_timer[i] >= 16'(ss_cycles(16'(SS_UNIT_CYC),
            buck_softstart_step_time_i[s]) - 16'h0001)) begin
          d.ss_timer[i] = 16'h0000;
          if (i >= 2 && q.ss_stage[i] == SS_LAST_34) begin
            d.ss_stage[i] = SS_FULL;
          end else begin
            d.ss_stage[i] = 3'(q.ss_stage[i] + 3'h1);
          end
        end else begin
          d.ss_timer[i] = 16'(q.ss_timer[i] + 16'h0001);
        end
      end
      // Bucks 3 and 4 run fixed 2 MHz, ganged or not
      fast = (i < 2) ? q.freq[i[0]] : 1'b0;
      d.tick[i] = phase_tick(q.sw_cnt, fast, buck_switch_phase_sel_i[s]);
    end
    // Hysteretic cap for bucks 3 and 4
    d.hyst_act[0] = (d.mode[2] == MODE_HYST);
    d.hyst_act[1] = (d.mode[3] == MODE_HYST);
    d.hyst_cap[0] = buck3_hysteretic_current_cap_i;
    d.hyst_cap[1] = q.gang ? buck3_hysteretic_current_cap_i : buck4_hysteretic_current_cap_i;
    d.gang_single = q.gang && (d.mode[2] == MODE_HYST || d.mode[2] == MODE_LDO);
    d.done = slew_done;
    // Regulators: switch mode bypasses regulation entirely
    d.reg_closed = regulator_switch_mode_i & regulator_enable_i;
    d.reg_reg = ~regulator_switch_mode_i & regulator_enable_i;
    d.reg_dis = ~regulator_switch_mode_i & ~regulator_enable_i
      & ~regulator_off_discharge_sel_i;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.freq <= FREQ_RESET;
      q.cap <= CAP_RESET;
      q.gang <= GANG_RESET;
      q.done <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign buck_output_capacitance_sel_o = q.cap;
  assign buck_switch_freq_sel_o = q.freq;
  assign buck_gang_enable_o = q.gang;
  assign buck_switch_tick_o = q.tick;
  assign buck_power_on_o = q.pwr;
  assign buck_ilim_stage_o = q.ss_stage;
  assign buck_target_voltage_o = q.tgt;
  assign buck_mode_o = q.mode;
  assign buck_hyst_cap_o = q.hyst_cap;
  assign buck_hyst_cap_active_o = q.hyst_act;
  assign buck_gang_single_limit_o = q.gang_single;
  assign buck_discharge_o = q.discharge;
  assign buck1_scaling_done_pin_o = q.done[0];
  assign buck2_scaling_done_pin_o = q.done[1];
  assign regulator_switch_closed_o = q.reg_closed;
  assign regulator_regulate_o = q.reg_reg;
  assign regulator_discharge_o = q.reg_dis;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_ss_stage_climb: assert property (
    q.pwr[0] && $past(q.pwr[0]) && $changed(q.ss_stage[0])
      |-> q.ss_stage[0] == 3'($past(q.ss_stage[0]) + 3'h1))
    else $error("Buck 1 soft-start skipped a stage");
  a_ss_short_seq: assert property (
    !(q.ss_stage[2] inside {3'h3, 3'h4, 3'h5, 3'h6}))
    else $error("Buck 3 used too many soft-start stages");
  a_hyst_cap_value: assert property (
    q.hyst_act[0] |-> q.hyst_cap[0] == $past(buck3_hysteretic_current_cap_i))
    else $error("Buck 3 hysteretic cap not applied");
  a_cap_frozen: assert property (
    !$past(nv_load_i) |-> $stable(q.cap))
    else $error("Capacitance setting changed without configuration load");
  a_buck_discharge: assert property (
    q.discharge[0] |-> !$past(buck_enable_i[0]) && !$past(buck_off_discharge_sel_i[0]))
    else $error("Buck 1 discharged while enabled or floating");
  a_buck3_fixed_rate: assert property (
    q.tick[2] && $stable(buck_switch_phase_sel_i[2]) |-> ##100 q.tick[2])
    else $error("Buck 3 not switching at 2 MHz");
  a_scaling_wins: assert property (
    buck_scaling_source_i[0] == SCALING_SRC_SOFT || voltage_scaling_pin_i[0]
      |-> slew_tgt[0] == buck_alternate_voltage_i[0])
    else $error("Alternate voltage did not take precedence");
  a_done_follows: assert property (
    !slew_done[0] |=> !q.done[0])
    else $error("Done pin high during a slew");
  a_gang_follow: assert property (
    q.gang && $past(q.gang) |-> q.tgt[3] == q.tgt[2] && q.mode[3] == q.mode[2])
    else $error("Ganged buck 4 not following buck 3");
  a_gang_no_auto: assert property (
    q.gang && $past(q.gang) && $past(nrst_i) |-> q.mode[2] != MODE_AUTO)
    else $error("Ganged pair left in auto mode");
  a_reg_switch: assert property (
    q.reg_closed[0] |-> $past(regulator_switch_mode_i[0] && regulator_enable_i[0]))
    else $error("Regulator switch closed without enable");

  c_ss_full: cover property (q.ss_stage[0] == SS_FULL);
  c_scaling_pin: cover property ($fell(q.done[0]) ##[1:1000] $rose(q.done[0]));
  c_gang_single: cover property (q.gang_single);

endmodule : buck_ldo_ctrl
`default_nettype wire

// *** bench/scaling_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Processor driving the scaling select pins
// ----------------------------------------
module scaling_pin_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] req_i,
  input wire logic slow_i,
  output logic [1:0] pin_o
);
  logic [1:0] d1_q;
  logic [1:0] d2_q;
  // Slow answer lags two cycles behind the fast one, so the bench never sees an instant pin
  // Bench drives req_i at the falling edge; sampling on the rising edge avoids a race
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      d1_q <= 2'h0;
      d2_q <= 2'h0;
      pin_o <= 2'h0;
    end else begin
      d1_q <= req_i;
      d2_q <= d1_q;
      pin_o <= slow_i ? d2_q : req_i;
    end
  end
endmodule : scaling_pin_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import buck_ldo_pkg::*;
  localparam int unsigned SS_U = 8;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic nv_load_i = 1'b0;
  logic nv_gang_enable_i = 1'b0;
  logic sleep_i = 1'b0;
  logic [1:0] nv_switch_freq_sel_i = 2'h0;
  logic [1:0] buck3_hysteretic_current_cap_i = 2'h0;
  logic [1:0] buck4_hysteretic_current_cap_i = 2'h1;
  logic [N_BUCK-1:0][1:0] nv_output_capacitance_sel_i = 8'h00;
  logic [N_BUCK-1:0][1:0] buck_softstart_step_time_i = 8'h00;
  logic [N_BUCK-1:0][1:0] buck_switch_phase_sel_i = 8'h10;
  logic [N_BUCK-1:0][1:0] buck_on_mode_i = 8'h00;
  logic [N_BUCK-1:0][1:0] buck_sleep_mode_i = 8'h00;
  logic [N_BUCK-1:0][1:0] buck_hwc_mode_i = 8'h00;
  logic [N_BUCK-1:0] buck_enable_i = 4'h0;
  logic [N_BUCK-1:0] buck_off_discharge_sel_i = 4'h0;
  logic [N_BUCK-1:0] hardware_control_input_i = 4'h0;
  logic [N_BUCK-1:0][VSEL_W-1:0] buck_on_state_voltage_i = '0;
  logic [N_BUCK-1:0][VSEL_W-1:0] buck_sleep_voltage_i = '0;
  logic [N_BUCK-1:0][VSEL_W-1:0] buck_hwc_voltage_i = '0;
  logic [1:0][VSEL_W-1:0] buck_alternate_voltage_i = '0;
  logic [1:0][1:0] buck_scaling_source_i = 4'h0;
  logic [1:0][1:0] buck_ramp_rate_i = 4'h0;
  logic [N_REG-1:0] regulator_enable_i = '0;
  logic [N_REG-1:0] regulator_switch_mode_i = '0;
  logic [N_REG-1:0] regulator_off_discharge_sel_i = '0;
  logic [1:0] pin_req = 2'h0;
  logic pin_slow = 1'b1;
  wire logic [1:0] voltage_scaling_pin_i;
  logic [N_BUCK-1:0][1:0] buck_output_capacitance_sel_o, buck_mode_o;
  logic [1:0] buck_switch_freq_sel_o, buck_hyst_cap_active_o;
  logic buck_gang_enable_o, buck_gang_single_limit_o;
  logic buck1_scaling_done_pin_o, buck2_scaling_done_pin_o;
  logic [N_BUCK-1:0] buck_switch_tick_o, buck_power_on_o, buck_discharge_o;
  logic [N_BUCK-1:0][2:0] buck_ilim_stage_o;
  logic [N_BUCK-1:0][VSEL_W-1:0] buck_target_voltage_o;
  logic [1:0][1:0] buck_hyst_cap_o;
  logic [N_REG-1:0] regulator_switch_closed_o, regulator_regulate_o, regulator_discharge_o;
  wire logic [1:0] done_w = {buck2_scaling_done_pin_o, buck1_scaling_done_pin_o};
  int mismatches = 0;
  int total_checks = 0;

  buck_ldo_ctrl #(.SS_UNIT_CYC(SS_U)) uut (.clk_i, .nrst_i, .nv_load_i, .nv_switch_freq_sel_i,
    .nv_output_capacitance_sel_i, .nv_gang_enable_i, .sleep_i, .buck_enable_i,
    .buck_softstart_step_time_i, .buck_off_discharge_sel_i, .buck_switch_phase_sel_i,
    .buck_on_state_voltage_i, .buck_sleep_voltage_i, .buck_on_mode_i, .buck_sleep_mode_i,
    .hardware_control_input_i, .buck_hwc_voltage_i, .buck_hwc_mode_i,
    .buck_alternate_voltage_i, .buck_scaling_source_i, .voltage_scaling_pin_i,
    .buck_ramp_rate_i, .buck3_hysteretic_current_cap_i, .buck4_hysteretic_current_cap_i,
    .regulator_enable_i, .regulator_switch_mode_i, .regulator_off_discharge_sel_i,
    .buck_output_capacitance_sel_o, .buck_switch_freq_sel_o, .buck_gang_enable_o,
    .buck_switch_tick_o, .buck_power_on_o, .buck_ilim_stage_o, .buck_target_voltage_o,
    .buck_mode_o, .buck_hyst_cap_o, .buck_hyst_cap_active_o, .buck_gang_single_limit_o,
    .buck_discharge_o, .buck1_scaling_done_pin_o, .buck2_scaling_done_pin_o,
    .regulator_switch_closed_o, .regulator_regulate_o, .regulator_discharge_o);

  scaling_pin_model proc (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(pin_req), .slow_i(pin_slow),
    .pin_o(voltage_scaling_pin_i));

  always #2.5 clk_i = ~clk_i;

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic tick_gap(input int a, input int b, output int n);
    int k;
    for (k = 0; k < 300 && buck_switch_tick_o[a] !== 1'b1; k++) @(negedge clk_i);
    @(negedge clk_i);
    n = 1;
    while (n < 300 && buck_switch_tick_o[b] !== 1'b1) begin
      @(negedge clk_i);
      n++;
    end
  endtask : tick_gap

  // Slew must be under way, then finish on the expected code
  task automatic settle(input int b, input logic [VSEL_W-1:0] e);
    int n;
    cyc(8);
    check(done_w[b], 1'b0);
    n = 0;
    while (done_w[b] !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    check(buck_target_voltage_o[b], e);
  endtask : settle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_config();
    int n;
    check(done_w, 2'h3);
    // Buck 1 set fast (4 MHz); buck 2 kept slow at 2 MHz
    nv_switch_freq_sel_i = 2'h1;
    nv_output_capacitance_sel_i = 8'hE4;
    cyc(3);
    check(buck_output_capacitance_sel_o, 8'h00);
    check(buck_switch_freq_sel_o, 2'h0);
    nv_load_i = 1'b1;
    cyc(1);
    nv_load_i = 1'b0;
    nv_output_capacitance_sel_i = 8'h1B;
    cyc(3);
    check(buck_output_capacitance_sel_o, 8'hE4);
    check(buck_switch_freq_sel_o, 2'h1);
    tick_gap(0, 0, n);
    check(n, SW_CYC_4M);
    tick_gap(2, 2, n);
    check(n, SW_CYC_2M);
    tick_gap(1, 2, n);
    check(n, PHASE_STEP_2M);
    $display("test config done");
  endtask : t_config

  task automatic t_softstart(input int b, input logic [1:0] sel, input logic flt);
    logic [2:0] prev;
    logic [2:0] e;
    int n;
    int k;
    int idx;
    buck_softstart_step_time_i[b] = sel;
    buck_off_discharge_sel_i[b] = flt;
    buck_enable_i[b] = 1'b1;
    cyc(2);
    check(buck_power_on_o[b], 1'b1);
    prev = buck_ilim_stage_o[b];
    check(prev, 3'h0);
    n = 1;
    idx = 0;
    for (k = 0; k < 2000 && prev !== SS_FULL; k++) begin
      cyc(1);
      if (buck_ilim_stage_o[b] !== prev) begin
        idx++;
        e = (b < 2 || idx < 3) ? 3'(idx) : SS_FULL;
        check(buck_ilim_stage_o[b], e);
        if (idx > 1 && idx < 7) check(n, SS_U << sel);
        prev = buck_ilim_stage_o[b];
        n = 0;
      end
      n++;
    end
    check(idx, (b < 2) ? 7 : 3);
    buck_enable_i[b] = 1'b0;
    cyc(3);
    check(buck_discharge_o[b], !flt);
    check(buck_ilim_stage_o[b], 3'h0);
    buck_enable_i[b] = 1'b1;
    $display("test softstart done");
  endtask : t_softstart

  task automatic t_slew(input logic [1:0] rate);
    logic [VSEL_W-1:0] v0;
    int n;
    v0 = buck_target_voltage_o[0];
    buck_ramp_rate_i[0] = rate;
    buck_on_state_voltage_i[0] = v0 + 7'h2;
    cyc(3);
    check(buck1_scaling_done_pin_o, 1'b0);
    n = 0;
    while (buck_target_voltage_o[0] === v0 && n < 3000) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (buck_target_voltage_o[0] === v0 + 7'h1 && n < 3000) begin
      check(buck1_scaling_done_pin_o, 1'b0);
      cyc(1);
      n++;
    end
    check(n, RAMP_BASE_CYC << rate);
    check(buck_target_voltage_o[0], v0 + 7'h2);
    cyc(3);
    check(buck1_scaling_done_pin_o, 1'b1);
    $display("test slew done");
  endtask : t_slew

  task automatic t_scaling();
    logic [VSEL_W-1:0] v;
    v = buck_target_voltage_o[0];
    buck_hwc_voltage_i[0] = v + 7'h1;
    hardware_control_input_i[0] = 1'b1;
    settle(0, v + 7'h1);
    buck_alternate_voltage_i[0] = v + 7'h2;
    buck_scaling_source_i[0] = SCALING_SRC_SOFT;
    settle(0, v + 7'h2);
    buck_scaling_source_i[0] = 2'h0;
    settle(0, v + 7'h1);
    pin_req[0] = 1'b1;
    settle(0, v + 7'h2);
    pin_req[0] = 1'b0;
    hardware_control_input_i[0] = 1'b0;
    buck_sleep_voltage_i[0] = v + 7'h5;
    sleep_i = 1'b1;
    cyc(250);
    buck_sleep_voltage_i[0] = v;
    settle(0, v);
    buck_alternate_voltage_i[1] = 7'h3;
    pin_slow = 1'b0;
    pin_req[1] = 1'b1;
    settle(1, 7'h3);
    $display("test scaling done");
  endtask : t_scaling

  task automatic t_buck3();
    sleep_i = 1'b0;
    buck_on_mode_i[2] = MODE_HYST;
    buck_on_state_voltage_i[2] = 7'h21;
    buck3_hysteretic_current_cap_i = 2'h2;
    cyc(3);
    check(buck_target_voltage_o[2], 7'h21);
    check(buck_hyst_cap_active_o[0], 1'b1);
    check(buck_hyst_cap_o[0], 2'h2);
    sleep_i = 1'b1;
    buck_sleep_mode_i[2] = MODE_LDO;
    buck_sleep_voltage_i[2] = 7'h33;
    cyc(3);
    check({buck_mode_o[2], buck_target_voltage_o[2]}, {MODE_LDO, 7'h33});
    hardware_control_input_i[2] = 1'b1;
    buck_hwc_mode_i[2] = MODE_FORCED_CONTINUOUS_MODE;
    buck_hwc_voltage_i[2] = 7'h44;
    cyc(3);
    check({buck_mode_o[2], buck_target_voltage_o[2]}, {MODE_FORCED_CONTINUOUS_MODE, 7'h44});
    hardware_control_input_i[2] = 1'b0;
    sleep_i = 1'b0;
    $display("test buck3 done");
  endtask : t_buck3

  task automatic t_gang();
    buck_on_mode_i[2] = MODE_AUTO;
    buck_on_mode_i[3] = MODE_LDO;
    buck_enable_i[3] = 1'b0;
    nv_gang_enable_i = 1'b1;
    nv_load_i = 1'b1;
    cyc(1);
    nv_load_i = 1'b0;
    cyc(3);
    check(buck_gang_enable_o, 1'b1);
    check(buck_power_on_o[3], 1'b1);
    check(buck_target_voltage_o[3], 7'h21);
    check({buck_mode_o[3], buck_mode_o[2]}, {MODE_FORCED_CONTINUOUS_MODE, MODE_FORCED_CONTINUOUS_MODE});
    buck_on_mode_i[2] = MODE_HYST;
    cyc(3);
    check(buck_gang_single_limit_o, 1'b1);
    check(buck_mode_o[3], MODE_HYST);
    check(buck_hyst_cap_o, 4'hA);
    check(buck_hyst_cap_active_o, 2'h3);
    $display("test gang done");
  endtask : t_gang

  // Switch mode only after power-on, by the software side
  task automatic t_regulator();
    regulator_enable_i = 10'h3C3;
    regulator_switch_mode_i = 10'h30F;
    regulator_off_discharge_sel_i = 10'h0E0;
    cyc(3);
    check(regulator_switch_closed_o, 10'h303);
    check(regulator_regulate_o, 10'h0C0);
    check(regulator_discharge_o, 10'h010);
    $display("test regulator done");
  endtask : t_regulator

  initial begin
    cyc(5);
    nrst_i = 1'b1;
    cyc(2);
    t_config();
    t_softstart(0, 2'h1, 1'b0);
    t_softstart(2, 2'h2, 1'b1);
    t_slew(2'h1);
    t_scaling();
    t_buck3();
    t_gang();
    t_regulator();
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
